// [logic/sfe_params.svh]
// constants of the serial front end: widths, opcodes, reset values
// assumes inclusion by the package and design files by bare name
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH

// ****************************************
// widths
// ****************************************
`define SFE_BYTE_W        8
`define SFE_IDX_W         10
`define SFE_BIT_LAST      3'h7
// ****************************************
// opcodes and counts
// ****************************************
`define SFE_OP_WRITE      8'h02
`define SFE_OP_STATUS_WR  8'h01
`define SFE_WRITE_MIN     10'h004
`define SFE_STATUS_MIN    10'h002
`define SFE_BYTE_RST      8'h00

`endif

// [logic/sfe_pkg.sv]
// types shared by the serial front end modules
// assumes sfe_params.svh is reachable on the include path
package sfe_pkg;
`include "sfe_params.svh"
	typedef enum logic [4:0] {
		ST_UNARMED = 5'h01,
		ST_IDLE    = 5'h02,
		ST_SEL     = 5'h04,
		ST_SETTLE  = 5'h08,
		ST_EVAL    = 5'h10
	} sfe_state_e;

	typedef struct packed {
		logic                    pause;
		logic [2:0]              bits;
		logic [`SFE_BYTE_W-1:0]  shreg;
		logic [`SFE_BYTE_W-1:0]  data;
		logic [`SFE_BYTE_W-1:0]  first;
		logic [`SFE_IDX_W-1:0]   idx;
		logic [`SFE_IDX_W-1:0]   data_idx;
		logic                    tgl;
	} sfe_rx_s;

	typedef struct packed {
		logic                    en_m;
		logic                    en;
		logic [`SFE_BYTE_W-1:0]  shreg;
		logic                    sdo;
		logic                    drive;
	} sfe_tx_s;
endpackage

// [logic/sfe_link_if.sv]
// signals between the core and the serial-clock side of the front end
// assumes one core, one receiver and one transmitter per instance
`timescale 1ns/1ps
interface sfe_link_if;
	logic        sclk;
	logic        cs_n;
	logic        sdi;
	logic        hold_n;
	logic        sys_rst;
	logic        link_rst;
	logic        armed;
	logic        fresh;
	logic        pause;
	logic [2:0]  bits;
	logic [7:0]  rx_byte;
	logic [7:0]  rx_first;
	logic [9:0]  rx_idx;
	logic [9:0]  rx_count;
	logic        rx_tgl;
	logic        tx_en;
	logic [7:0]  tx_hold;
	logic        sdo;
	logic        drive;

	modport rx (input sclk, cs_n, sdi, hold_n, sys_rst, link_rst, armed,
		output fresh, pause, bits, rx_byte, rx_first, rx_idx, rx_count, rx_tgl);
	modport tx (input sclk, cs_n, sys_rst, armed, fresh, pause, bits, tx_en, tx_hold,
		output sdo, drive);
	modport core (output sclk, cs_n, sdi, hold_n, sys_rst, link_rst, armed, tx_en, tx_hold,
		input fresh, pause, bits, rx_byte, rx_first, rx_idx, rx_count, rx_tgl, sdo, drive);
endinterface

// [logic/sfe_rx.sv]
// receive shifter, rising edges of the serial clock
// assumes chip select and pause are stable around serial clock edges
`timescale 1ns/1ps
module sfe_rx (
	sfe_link_if.rx lk
);
	import sfe_pkg::*;

	sfe_rx_s s;
	sfe_rx_s next_s;
	logic    fresh;

	always_comb begin
		next_s = s;
		if (!lk.cs_n && lk.armed) begin
			next_s.pause = !lk.hold_n;
			if (lk.hold_n) begin
				next_s.shreg = {s.shreg[6:0], lk.sdi};
				next_s.bits  = fresh ? s.bits + 3'h1 : 3'h1;
				if (!fresh) begin
					next_s.shreg = {7'h00, lk.sdi};
					next_s.idx   = '0;
				end else if (s.bits == `SFE_BIT_LAST) begin
					next_s.data     = {s.shreg[6:0], lk.sdi};
					next_s.data_idx = s.idx;
					next_s.idx      = s.idx + 10'h001;
					next_s.tgl      = ~s.tgl;
					if (s.idx == '0)
						next_s.first = {s.shreg[6:0], lk.sdi};
				end
			end
		end
	end

	// state survives deselect so the core can judge the finished frame
	always_ff @(posedge lk.sclk or posedge lk.sys_rst) begin
		if (lk.sys_rst)
			s <= '0;
		else
			s <= next_s;
	end

	// frame start marker; a deselect, even while paused, clears it
	always_ff @(posedge lk.sclk or posedge lk.link_rst) begin
		if (lk.link_rst)
			fresh <= 1'b0;
		else if (!lk.cs_n && lk.hold_n)
			fresh <= 1'b1;
	end

	assign lk.fresh    = fresh;
	assign lk.pause    = s.pause;
	assign lk.bits     = s.bits;
	assign lk.rx_byte  = s.data;
	assign lk.rx_first = s.first;
	assign lk.rx_idx   = s.data_idx;
	assign lk.rx_count = s.idx;
	assign lk.rx_tgl   = s.tgl;

	bit_count_step_a: assert property (@(posedge lk.sclk) disable iff (lk.link_rst)
		(fresh && lk.hold_n) |=> s.bits == $past(s.bits) + 3'h1)
		else $error("bit position did not advance on a rising edge");
endmodule

// [logic/sfe_tx.sv]
// transmit shifter, falling edges of the serial clock
// assumes tx_hold is stable for a byte time before each byte boundary
`timescale 1ns/1ps
module sfe_tx (
	sfe_link_if.tx lk
);
	import sfe_pkg::*;

	sfe_tx_s s;
	sfe_tx_s next_s;
	logic    boundary;

	assign boundary = lk.fresh && lk.bits == 3'h0;

	always_comb begin
		next_s      = s;
		next_s.en_m = lk.tx_en;
		next_s.en   = s.en_m;
		if (!lk.cs_n && lk.armed && !lk.pause) begin
			if (boundary) begin
				next_s.shreg = {lk.tx_hold[6:0], 1'b0};
				next_s.sdo   = lk.tx_hold[7];
				next_s.drive = s.en;
			end else begin
				next_s.sdo   = s.shreg[7];
				next_s.shreg = {s.shreg[6:0], 1'b0};
			end
			if (!lk.fresh)
				next_s.drive = 1'b0;
		end
	end

	always_ff @(negedge lk.sclk or posedge lk.sys_rst) begin
		if (lk.sys_rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign lk.sdo   = s.sdo;
	assign lk.drive = s.drive;

	msb_first_shift_a: assert property (@(negedge lk.sclk) disable iff (lk.sys_rst)
		(!lk.cs_n && lk.armed && !lk.pause && lk.fresh && !boundary) |=> s.sdo == $past(s.shreg[7]))
		else $error("output bit is not the next bit of the byte");
endmodule

// [logic/sfe_front_end.sv]
// serial front end of a byte-wide serial memory: pins to bytes and back
// assumes a decoder on ref_clk_in consumes bytes and supplies read data
`timescale 1ns/1ps
`include "sfe_params.svh"

// How it works
// - input bit taken on every rising serial clock edge while selected and not paused
// - output bit changes only on falling serial clock edges
// - all bytes travel most significant bit first both ways
// - first rising edge after select takes the first bit
// - read data starts at the falling edge after the last input bit
// - deselected means output floating
// - deselect gives standby unless a write cycle still runs
// - a select already low at reset is ignored until a falling edge
// - reset leaves device deselected, in standby, status bits cleared
// - no instruction taken before reset is released
// - pause only starts while selected
// - pause starts when pause input falls with the clock low
// - while paused output floats, clock and input ignored
// - pause keeps the bit and byte position
// - deselect while paused resets interface logic, status bits kept
// - complete write with whole bytes still launches on paused deselect
// - deselect must fall between last bit edge and next rising edge
// - writes need a clock count that is a multiple of eight
module sfe_front_end (
	input  wire logic        ref_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        sclk_in,
	input  wire logic        cs_n_in,
	input  wire logic        sdi_in,
	input  wire logic        hold_n_in,
	input  wire logic        write_in_progress_in,
	input  wire logic [7:0]  tx_byte_in,
	input  wire logic        tx_enable_in,
	output logic             sdo_out,
	output logic             sdo_oe_n_out,
	output logic             selected_out,
	output logic             active_power_out,
	output logic             standby_out,
	output logic             paused_out,
	output logic             clock_idle_polarity_out,
	output logic             byte_valid_out,
	output logic [7:0]       byte_out,
	output logic [9:0]       byte_index_out,
	output logic             write_launch_out,
	output logic             write_kind_out,
	output logic             discard_out
);
	import sfe_pkg::*;

	// ****************************************
	// core state
	// ****************************************
	typedef struct packed {
		sfe_state_e              state;
		logic                    cs_m;
		logic                    cs_s;
		logic                    hold_m;
		logic                    hold_s;
		logic                    sclk_m;
		logic                    sclk_s;
		logic                    tg_m;
		logic                    tg_s;
		logic                    tg_d;
		logic                    got_byte;
		logic                    selected;
		logic                    active;
		logic                    paused;
		logic                    polarity;
		logic                    bvalid;
		logic [`SFE_BYTE_W-1:0]  byte_q;
		logic [`SFE_IDX_W-1:0]   idx;
		logic                    load_tx;
		logic [`SFE_BYTE_W-1:0]  tx_hold;
		logic                    launch;
		logic                    kind;
		logic                    discard;
	} sfe_core_s;

	sfe_core_s  st;
	sfe_core_s  next_st;
	sfe_link_if lk ();

	logic byte_evt;
	logic armed;
	logic paused_now;
	logic is_write;
	logic is_status;
	logic aligned;
	logic enough;
	logic eval_ok;
	logic link_live;

	function automatic logic min_reached(input logic [`SFE_IDX_W-1:0] cnt,
		input logic [`SFE_IDX_W-1:0] need);
		min_reached = cnt >= need;
	endfunction

	// ****************************************
	// link side
	// ****************************************
	assign armed       = st.state != ST_UNARMED;
	assign lk.sclk     = sclk_in;
	assign lk.cs_n     = cs_n_in;
	assign lk.sdi      = sdi_in;
	assign lk.hold_n   = hold_n_in;
	assign lk.sys_rst  = sys_rst_in;
	assign lk.armed    = armed;
	assign lk.link_rst = sys_rst_in | cs_n_in | ~armed;
	assign lk.tx_en    = tx_enable_in;
	assign lk.tx_hold  = st.tx_hold;

	sfe_rx u_rx (
		.lk (lk.rx)
	);

	sfe_tx u_tx (
		.lk (lk.tx)
	);

	// with the clock high the pause state frozen at the last rise holds;
	// with it low the pin itself decides, so a pause begins only then
	assign paused_now = sclk_in ? lk.pause : ~hold_n_in;

	// ****************************************
	// output pin
	// ****************************************
	// only a frame that has taken a whole byte may drive; a drive flag left over
	// from the closing falling edge of the last frame must not reach the new one
	assign link_live    = lk.fresh && lk.rx_count != '0;
	assign sdo_out      = lk.sdo;
	assign sdo_oe_n_out = ~(~cs_n_in & armed & lk.drive & link_live & ~paused_now);

	// ****************************************
	// frame judgement
	// ****************************************
	// counts and first byte are frozen while deselected, so a plain read is safe
	assign is_write  = lk.rx_first == `SFE_OP_WRITE;
	assign is_status = lk.rx_first == `SFE_OP_STATUS_WR;
	assign aligned   = lk.bits == 3'h0;
	assign enough    = is_write ? min_reached(lk.rx_count, `SFE_WRITE_MIN)
		: min_reached(lk.rx_count, `SFE_STATUS_MIN);
	assign eval_ok   = st.got_byte && (is_write || is_status) && aligned && enough;
	assign byte_evt  = st.tg_s ^ st.tg_d;

	always_comb begin
		next_st         = st;
		next_st.cs_m    = cs_n_in;
		next_st.cs_s    = st.cs_m;
		next_st.hold_m  = hold_n_in;
		next_st.hold_s  = st.hold_m;
		next_st.sclk_m  = sclk_in;
		next_st.sclk_s  = st.sclk_m;
		next_st.tg_m    = lk.rx_tgl;
		next_st.tg_s    = st.tg_m;
		next_st.tg_d    = st.tg_s;
		next_st.bvalid  = 1'b0;
		next_st.launch  = 1'b0;
		next_st.discard = 1'b0;
		next_st.load_tx = st.bvalid;
		if (st.load_tx)
			next_st.tx_hold = tx_byte_in;
		if (byte_evt && armed) begin
			next_st.bvalid   = 1'b1;
			next_st.byte_q   = lk.rx_byte;
			next_st.idx      = lk.rx_idx;
			next_st.got_byte = 1'b1;
		end
		case (st.state)
			ST_UNARMED: begin
				// only a high level seen after reset opens the door
				if (st.cs_s)
					next_st.state = ST_IDLE;
			end
			ST_IDLE: begin
				if (!st.cs_s) begin
					next_st.state    = ST_SEL;
					next_st.selected = 1'b1;
					next_st.got_byte = 1'b0;
					next_st.polarity = st.sclk_s;
				end
			end
			ST_SEL: begin
				if (st.cs_s) begin
					next_st.state    = ST_SETTLE;
					next_st.selected = 1'b0;
				end
			end
			ST_SETTLE: begin
				// one more cycle lets a last byte toggle clear its synchroniser
				next_st.state = ST_EVAL;
			end
			ST_EVAL: begin
				next_st.state = ST_IDLE;
				if (st.got_byte && (is_write || is_status)) begin
					next_st.launch  = eval_ok;
					next_st.kind    = is_status;
					next_st.discard = ~eval_ok;
				end
			end
			default: begin
				next_st.state = ST_UNARMED;
			end
		endcase
		next_st.active = next_st.selected | write_in_progress_in;
		next_st.paused = next_st.selected & ~st.hold_s;
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st       <= '0;
			st.state <= ST_UNARMED;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign selected_out            = st.selected;
	assign active_power_out        = st.active;
	assign standby_out             = ~st.active;
	assign paused_out              = st.paused;
	assign clock_idle_polarity_out = st.polarity;
	assign byte_valid_out          = st.bvalid;
	assign byte_out                = st.byte_q;
	assign byte_index_out          = st.idx;
	assign write_launch_out        = st.launch;
	assign write_kind_out          = st.kind;
	assign discard_out             = st.discard;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	sequence closing_s;
		st.state == ST_SEL ##1 st.state == ST_SETTLE ##1 st.state == ST_EVAL;
	endsequence

	sequence pulse_s(sig);
		sig ##1 !sig;
	endsequence

	launch_on_close_a: assert property (
		closing_s ##0 eval_ok |=> pulse_s(write_launch_out))
		else $error("whole write frame did not launch on deselect");

	launch_needs_frame_a: assert property (
		write_launch_out |-> $past(st.state) == ST_EVAL && $past(aligned))
		else $error("write launched without aligned frame");

	discard_partial_a: assert property (
		closing_s ##0 (st.got_byte && is_write && !aligned) |=> discard_out && !write_launch_out)
		else $error("unaligned write not discarded");

	unarmed_quiet_a: assert property (
		st.state == ST_UNARMED |-> !selected_out && !byte_valid_out && sdo_oe_n_out)
		else $error("activity before first select edge");

	float_deselect_a: assert property (
		cs_n_in |-> sdo_oe_n_out)
		else $error("output driven while deselected");

	float_paused_a: assert property (
		(!sclk_in && !hold_n_in) |-> sdo_oe_n_out)
		else $error("output driven during pause");

	standby_follow_a: assert property (
		(!selected_out && !write_in_progress_in && st.state == ST_IDLE)
		##1 (!write_in_progress_in && st.state == ST_IDLE) |-> standby_out)
		else $error("no standby after deselect with idle write engine");

	busy_keeps_active_a: assert property (
		write_in_progress_in |=> active_power_out && !standby_out)
		else $error("standby while a write cycle runs");

	byte_pulse_a: assert property (
		byte_valid_out |=> !byte_valid_out)
		else $error("byte strobe longer than one cycle");

	first_index_a: assert property (
		(byte_valid_out && !$past(st.got_byte)) |-> byte_index_out == '0)
		else $error("first byte of a frame has nonzero index");

	select_path_a: assert property (
		$rose(selected_out) |-> $past(st.state) == ST_IDLE ##[1:3] st.state == ST_SEL)
		else $error("select entered from wrong state");

	// ****************************************
	// checks on judgement and power
	// ****************************************
	// a status write needs its opcode and one data byte, anything shorter is dropped
	short_status_a: assert property (
		closing_s ##0 (st.got_byte && is_status && lk.rx_count < `SFE_STATUS_MIN) |=> discard_out)
		else $error("short status write not discarded");

	other_quiet_a: assert property (
		closing_s ##0 (st.got_byte && !is_write && !is_status) |=> !write_launch_out && !discard_out)
		else $error("pulse on a frame that is no write");

	launch_discard_excl_a: assert property (
		!(write_launch_out && discard_out))
		else $error("launch and discard together");

	launch_kind_a: assert property (
		write_launch_out |-> write_kind_out == $past(is_status))
		else $error("write kind does not match the opcode");

	paused_select_a: assert property (
		paused_out |-> selected_out)
		else $error("paused while deselected");

	byte_needs_arm_a: assert property (
		byte_valid_out |-> $past(armed))
		else $error("byte delivered before arming");

	unarmed_silent_a: assert property (
		st.state == ST_UNARMED |=> !write_launch_out && !discard_out)
		else $error("write pulse before arming");

	select_drop_a: assert property (
		(st.state == ST_SEL && st.cs_s) |=> !selected_out && st.state == ST_SETTLE)
		else $error("deselect not taken");

	select_active_a: assert property (
		selected_out |-> active_power_out)
		else $error("selected but not in active power");

	power_inverse_a: assert property (
		standby_out == !active_power_out)
		else $error("standby and active power disagree");

	// consecutive bytes of one frame carry consecutive indices
	index_step_a: assert property (
		(byte_valid_out && $past(st.got_byte)) |-> byte_index_out == $past(byte_index_out) + 10'h001)
		else $error("byte index did not advance by one");
endmodule

// [tb/sfe_spi_master.sv]
// bus master model for the serial front end: clock modes 0 and 3, pause, deselect
// assumes the bench sequences every frame through the tasks below
`timescale 1ns/1ps
module sfe_spi_master (
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      sdi_out,
	output logic      hold_n_out,
	input  wire logic sdo_in,
	input  wire logic sdo_oe_n_in
);
	logic last;
	logic line;
	logic wp_n;

	// released line shows the inverse of its last level, so a float never looks right
	assign line = (sdo_oe_n_in === 1'b0) ? sdo_in : ~last;

	always @(sdo_in or sdo_oe_n_in) begin
		if (sdo_oe_n_in === 1'b0)
			last = sdo_in;
	end

	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out = 1'b0;
		hold_n_out = 1'b1;
		last = 1'b0;
		// write protect parked at one firm level and never moved, writes included
		wp_n = 1'b1;
	end

	// ********
	// frame steps
	// ********
	task automatic open_frame(input logic mode);
		sclk_out = mode;
		#0.7;
		cs_n_out = 1'b0;
		// idle level must outlast the select synchroniser so the mode is seen
		#6;
	endtask

	// data changes while the clock is low, sampled back at the rise
	task automatic put_bit(input logic b, output logic rb);
		sclk_out = 1'b0;
		sdi_out = b;
		#3;
		sclk_out = 1'b1;
		rb = line;
		#3;
	endtask

	// clock parked low first, then noise on clock and data while paused
	task automatic pause_on();
		sclk_out = 1'b0;
		#2;
		hold_n_out = 1'b0;
		repeat (3) begin
			#1.5 sclk_out = 1'b1;
			sdi_out = ~sdi_out;
			#1.5 sclk_out = 1'b0;
		end
	endtask

	task automatic pause_off();
		#2 hold_n_out = 1'b1;
		#2;
	endtask

	task automatic close_frame(input logic mode);
		if (!mode)
			sclk_out = 1'b0;
		#1 cs_n_out = 1'b1;
		#1 sclk_out = mode;
		sdi_out = ~sdi_out;
	endtask
endmodule

// [tb/spi_eeprom_serial_front_end_tb_top.sv]
// bench for the serial front end: master model, byte and launch scoreboards
// assumes sfe_front_end and sfe_spi_master compiled first; ref clock 4 ns, link 6 ns
`timescale 1ns/1ps
module spi_eeprom_serial_front_end_tb_top;
	logic        clk;
	logic        rst;
	logic        sclk;
	logic        cs_n;
	logic        sdi;
	logic        hold_n;
	logic        wr_busy;
	logic [7:0]  tx_byte;
	logic        tx_en;
	logic        sdo;
	logic        oe_n;
	logic        sel;
	logic        act;
	logic        stby;
	logic        paused;
	logic        pol;
	logic        bv;
	logic [7:0]  bdat;
	logic [9:0]  bidx;
	logic        wl;
	logic        wk;
	logic        disc;
	logic        r;
	logic [7:0]  v;
	logic [7:0]  seed = 8'h21;
	logic [17:0] exp_bytes[$];
	logic [17:0] exp_launch[$];
	logic [7:0]  rxq[$];
	int          n_errors = 0;
	int          total_checks = 0;

	sfe_front_end i_sfe_front_end (
		.ref_clk_in              (clk),
		.sys_rst_in              (rst),
		.sclk_in                 (sclk),
		.cs_n_in                 (cs_n),
		.sdi_in                  (sdi),
		.hold_n_in               (hold_n),
		.write_in_progress_in    (wr_busy),
		.tx_byte_in              (tx_byte),
		.tx_enable_in            (tx_en),
		.sdo_out                 (sdo),
		.sdo_oe_n_out            (oe_n),
		.selected_out            (sel),
		.active_power_out        (act),
		.standby_out             (stby),
		.paused_out              (paused),
		.clock_idle_polarity_out (pol),
		.byte_valid_out          (bv),
		.byte_out                (bdat),
		.byte_index_out          (bidx),
		.write_launch_out        (wl),
		.write_kind_out          (wk),
		.discard_out             (disc)
	);

	sfe_spi_master i_sfe_spi_master (
		.sclk_out    (sclk),
		.cs_n_out    (cs_n),
		.sdi_out     (sdi),
		.hold_n_out  (hold_n),
		.sdo_in      (sdo),
		.sdo_oe_n_in (oe_n)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ********
	// helpers
	// ********
	function automatic logic [7:0] next_rand();
		seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
		return seed;
	endfunction

	task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic pause_check(input logic release_it);
		i_sfe_spi_master.pause_on();
		repeat (8) @(posedge clk);
		#1;
		check("pause", 18'h3, {16'h0, paused, oe_n});
		if (release_it)
			i_sfe_spi_master.pause_off();
	endtask

	// pb: bit count at which to pause, drop: deselect while paused
	task automatic frame(input logic mode, input logic [7:0] op, input int nb, input int xb, input int pb,
			input logic drop);
		logic [7:0] b;
		logic [7:0] rb;
		int         n;
		n = 0;
		i_sfe_spi_master.open_frame(mode);
		for (int k = 0; k < nb; k++) begin
			b = (k == 0) ? op : next_rand();
			exp_bytes.push_back({k[9:0], b});
			for (int i = 7; i >= 0; i--) begin
				if (n == pb)
					pause_check(1'b1);
				i_sfe_spi_master.put_bit(b[i], rb[i]);
				n++;
			end
			rxq.push_back(rb);
			if (k == 0) begin
				@(posedge clk);
				#1;
				check("framing", {14'h0, 3'b110, mode}, {14'h0, sel, act, stby, pol});
			end
		end
		repeat (xb) i_sfe_spi_master.put_bit(1'b1, r);
		if (op == 8'h02 || op == 8'h01)
			exp_launch.push_back((xb == 0 && nb >= ((op == 8'h02) ? 4 : 2)) ? {17'h0, op == 8'h01} : 18'h2);
		if (drop) begin
			pause_check(1'b0);
			i_sfe_spi_master.close_frame(mode);
			repeat (8) @(posedge clk);
			#1;
			check("pause_drop", 18'h0, {17'h0, paused});
			i_sfe_spi_master.pause_off();
		end else begin
			i_sfe_spi_master.close_frame(mode);
		end
		repeat (20) @(posedge clk);
		#1;
		check("idle", 18'h3, {14'h0, sel, paused, stby, oe_n});
		check("left", 18'h0, 18'(exp_bytes.size() + exp_launch.size()));
	endtask

	// ********
	// scoreboards
	// ********
	always @(posedge clk) begin
		if (bv === 1'b1)
			check("byte", (exp_bytes.size() != 0) ? exp_bytes.pop_front() : {18{1'bx}}, {bidx, bdat});
		if (wl === 1'b1 || disc === 1'b1)
			check("launch", (exp_launch.size() != 0) ? exp_launch.pop_front() : {18{1'bx}},
				(disc === 1'b1) ? 18'h2 : {17'h0, wk});
	end

	// output must not move while the clock is high
	always @(posedge sclk) begin : sdo_watch
		logic held;
		held = sdo;
		#2.5;
		if (oe_n === 1'b0 && hold_n === 1'b1)
			check("sdo_stable", {17'h0, held}, {17'h0, sdo});
	end

	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end

	// ********
	// main sequence
	// ********
	initial begin
		rst = 1'b1;
		wr_busy = 1'b0;
		tx_en = 1'b0;
		tx_byte = 8'h00;
		repeat (4) @(posedge clk);
		#1;
		check("rst_state", 18'hA, {14'h0, stby, sel, oe_n, act});
		i_sfe_spi_master.open_frame(1'b0);
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		v = 8'h02;
		for (int i = 7; i >= 0; i--) i_sfe_spi_master.put_bit(v[i], r);
		i_sfe_spi_master.close_frame(1'b0);
		repeat (20) @(posedge clk);
		frame(1'b0, 8'h02, 4, 0, -1, 1'b0);
		frame(1'b1, 8'h01, 2, 0, -1, 1'b0);
		frame(1'b0, 8'h02, 3, 0, -1, 1'b0);
		frame(1'b1, 8'h02, 5, 3, -1, 1'b0);
		frame(1'b0, 8'h01, 1, 0, -1, 1'b0);
		frame(1'b1, 8'h06, 2, 0, -1, 1'b0);
		frame(1'b0, 8'h02, 4, 0, 13, 1'b0);
		frame(1'b1, 8'h02, 4, 0, -1, 1'b1);
		frame(1'b0, 8'h05, 2, 0, -1, 1'b0);
		for (int m = 0; m < 2; m++) begin
			tx_byte = next_rand();
			tx_en = 1'b1;
			rxq.delete();
			frame(m[0], 8'h03, 4, 0, -1, 1'b0);
			check("read_b2", {10'h0, tx_byte}, {10'h0, rxq[2]});
			check("read_b3", {10'h0, tx_byte}, {10'h0, rxq[3]});
			tx_en = 1'b0;
		end
		wr_busy = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		check("busy_power", 18'h2, {16'h0, act, stby});
		wr_busy = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		check("standby", 18'h1, {16'h0, act, stby});
		print_verdict();
	end
endmodule
